// ===== hw/sched_params.svh
// constants for the time-scheduled run sequencer
`ifndef SCHED_PARAMS_SVH
`define SCHED_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_STATE 12'h00C
`define REG_TIMER 12'h010
`define REG_PT_SET 12'h100
`define REG_PT_TIME 12'h200
`define REG_PT_SPAN 12'h078
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_ASSIGN_LSB 4
`define CTRL_UNIT_LSB 8
`define CTRL_RESET 32'h00000000
`define MODE_SCHED 4'h5
`define ASSIGN_GROUPS 3'h3
// ----------------------------------------
// schedule layout
// ----------------------------------------
`define NUM_GROUPS 3
`define PTS_PER_GROUP 10
`define NUM_POINTS 30
`define PT_LAST 4'h9
`define PT_UNSET 16'h270F
`define DIR_STOP 2'h0
`define DIR_FWD 2'h1
`define DIR_REV 2'h2
`define TIMER_HI_MAX 7'h63
`define TIMER_LO_MAX 6'h3B
`define TIMER_HI_SCALE 14'h0064
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define SECOND_NS 1000000000
`define SCHED_CYC_PER_SEC (`SECOND_NS / `CLK_PERIOD_NS)
`endif

// ===== hw/sched_pkg.sv
// types shared by the time-scheduled run sequencer
package sched_pkg;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RUN = 6'h02,
		ST_NEXT = 6'h04,
		ST_DONE = 6'h08,
		ST_HALT = 6'h10,
		ST_SPARE = 6'h20
	} state_t;
	// ----------------------------------------
	// terminal bundles
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] group_select;
		logic timer_clear_input;
		logic run_start_input;
		logic power_fail;
	} term_in_t;
	typedef struct packed {
		logic completion_output;
		logic group_three_active_output;
		logic group_two_active_output;
		logic group_one_active_output;
	} term_out_t;
endpackage

// ===== hw/time_scheduled_run_sequencer.sv
// time-scheduled run sequencer with wishbone register access
// Behaviour
// - group select inputs choose participating groups
// - timer clear forces reference timer zero
// - start with group clears timer, runs points
// - no run start while timer clear held
// - completion set at end, dropped on clear
// - assign setting 3 shows active group outputs
// - scheduled run only in operation mode 5
// - keypad or link mode blocks scheduled run
// - groups run ascending, timer zeroed between
// - after power loss stay stopped
// - direction 0 stop, 1 forward, 2 reverse
// - value 9999 marks point unset, skipped
// - ten consecutive points per group
// - timer counts to 99:59 in chosen unit
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`include "sched_params.svh"
module time_scheduled_run_sequencer #(
	parameter int unsigned CYC_PER_SEC = `SCHED_CYC_PER_SEC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire sched_pkg::term_in_t term_i,
	output sched_pkg::term_out_t term_o,
	output logic [15:0] freq_o,
	output logic [1:0] dir_o,
	output logic irq_o
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [2:0] status;
	logic [2:0] mask;
	logic [31:0] pt_set [`NUM_POINTS];
	logic [15:0] pt_time [`NUM_POINTS];
	sched_pkg::state_t state;
	logic [2:0] run_grps;
	logic [1:0] grp;
	logic [3:0] pidx;
	logic [6:0] t_hi;
	logic [5:0] t_lo;
	logic [5:0] sec_cnt;
	logic [31:0] presc;

	logic [3:0] op_mode;
	logic [2:0] out_assign;
	logic [1:0] time_unit;
	logic wr_stb;
	logic rd_stb;
	logic [4:0] ptr;
	logic [31:0] cur_set;
	logic [15:0] cur_time;
	logic [13:0] t_val;
	logic pt_unset;
	logic pt_due;
	logic run_ok;
	logic start_go;
	logic grp_go;
	logic [2:0] rem;
	logic tick;
	logic [2:0] ev;

	assign op_mode = ctrl[`CTRL_MODE_LSB +: 4];
	assign out_assign = ctrl[`CTRL_ASSIGN_LSB +: 3];
	assign time_unit = ctrl[`CTRL_UNIT_LSB +: 2];

	function automatic logic [1:0] first_grp(input logic [2:0] g);
		first_grp = g[0] ? 2'h0 : (g[1] ? 2'h1 : 2'h2);
	endfunction

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	// one wait state: ack rises the cycle after the request, writes land on the ack edge
	assign wr_stb = cyc_i & stb_i & we_i & ack_o;
	assign rd_stb = cyc_i & stb_i & ~ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (rd_stb) begin
			dat_o <= 32'h00000000;
			if (adr_i == `REG_CTRL) begin
				dat_o <= ctrl;
			end else if (adr_i == `REG_STATUS) begin
				dat_o[2:0] <= status;
			end else if (adr_i == `REG_MASK) begin
				dat_o[2:0] <= mask;
			end else if (adr_i == `REG_STATE) begin
				dat_o <= {16'h0000, term_o, pidx, grp, state};
			end else if (adr_i == `REG_TIMER) begin
				dat_o[13:0] <= t_val;
			end else if (adr_i >= `REG_PT_SET && adr_i < `REG_PT_SET + `REG_PT_SPAN) begin
				dat_o <= pt_set[adr_i[6:2]];
			end else if (adr_i >= `REG_PT_TIME && adr_i < `REG_PT_TIME + `REG_PT_SPAN) begin
				dat_o[15:0] <= pt_time[adr_i[6:2]];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `CTRL_RESET;
			mask <= 3'h0;
		end else if (wr_stb) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b] && adr_i == `REG_CTRL) begin
					ctrl[b*8 +: 8] <= dat_i[b*8 +: 8];
				end
			end
			if (sel_i[0] && adr_i == `REG_MASK) begin
				mask <= dat_i[2:0];
			end
		end
	end

	// schedule points: ten per group, group g at entries 10g..10g+9
	generate
		for (genvar n = 0; n < `NUM_POINTS; n++) begin : g_pt
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pt_set[n] <= {`PT_UNSET, `PT_UNSET};
					pt_time[n] <= `PT_UNSET;
				end else if (wr_stb) begin
					for (int b = 0; b < 4; b++) begin
						if (sel_i[b] && adr_i == `REG_PT_SET + 12'(n * 4)) begin
							pt_set[n][b*8 +: 8] <= dat_i[b*8 +: 8];
						end
					end
					for (int b = 0; b < 2; b++) begin
						if (sel_i[b] && adr_i == `REG_PT_TIME + 12'(n * 4)) begin
							pt_time[n][b*8 +: 8] <= dat_i[b*8 +: 8];
						end
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// point lookup
	// ----------------------------------------
	assign ptr = 5'(grp * `PTS_PER_GROUP) + 5'(pidx);
	assign cur_set = pt_set[ptr];
	assign cur_time = pt_time[ptr];
	assign t_val = 14'(t_hi * `TIMER_HI_SCALE) + 14'(t_lo);
	assign pt_unset = (cur_set[15:0] == `PT_UNSET) || (cur_set[31:16] == `PT_UNSET) ||
		(cur_time == `PT_UNSET);
	assign pt_due = ({2'h0, t_val} >= cur_time);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// keypad and link modes are any mode other than scheduled, so selects are ignored there
	assign run_ok = (op_mode == `MODE_SCHED) && (term_i.group_select != 3'h0) &&
		term_i.run_start_input && ~term_i.timer_clear_input;
	assign start_go = (state == sched_pkg::ST_IDLE) && run_ok && ~term_i.power_fail;
	assign rem = run_grps & ~(3'h1 << grp);
	assign grp_go = (state == sched_pkg::ST_NEXT) && (rem != 3'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= sched_pkg::ST_IDLE;
			run_grps <= 3'h0;
			grp <= 2'h0;
			pidx <= 4'h0;
		end else if (term_i.power_fail) begin
			state <= sched_pkg::ST_HALT;
		end else if (state != sched_pkg::ST_HALT &&
			(term_i.timer_clear_input || op_mode != `MODE_SCHED)) begin
			state <= sched_pkg::ST_IDLE;
		end else begin
			case (state)
				sched_pkg::ST_IDLE: begin
					if (start_go) begin
						run_grps <= term_i.group_select;
						grp <= first_grp(term_i.group_select);
						pidx <= 4'h0;
						state <= sched_pkg::ST_RUN;
					end
				end
				sched_pkg::ST_RUN: begin
					if (pt_unset || pt_due) begin
						if (pidx == `PT_LAST) begin
							state <= sched_pkg::ST_NEXT;
						end else begin
							pidx <= pidx + 4'h1;
						end
					end
				end
				sched_pkg::ST_NEXT: begin
					run_grps <= rem;
					pidx <= 4'h0;
					if (rem != 3'h0) begin
						grp <= first_grp(rem);
						state <= sched_pkg::ST_RUN;
					end else begin
						state <= sched_pkg::ST_DONE;
					end
				end
				sched_pkg::ST_DONE: begin
					state <= sched_pkg::ST_DONE;
				end
				sched_pkg::ST_HALT: begin
					// only a fresh start edge may rearm after a power dropout
					if (~term_i.run_start_input) begin
						state <= sched_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= sched_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// reference timer
	// ----------------------------------------
	assign tick = (presc == CYC_PER_SEC - 1) && (~time_unit[0] || sec_cnt == `TIMER_LO_MAX);

	always_ff @(posedge clk_i) begin
		if (rst_i || term_i.timer_clear_input || term_i.power_fail || start_go || grp_go) begin
			presc <= 32'h00000000;
			sec_cnt <= 6'h00;
			t_hi <= 7'h00;
			t_lo <= 6'h00;
		end else if (state == sched_pkg::ST_RUN) begin
			presc <= (presc == CYC_PER_SEC - 1) ? 32'h00000000 : presc + 32'h00000001;
			if (presc == CYC_PER_SEC - 1) begin
				sec_cnt <= (sec_cnt == `TIMER_LO_MAX) ? 6'h00 : sec_cnt + 6'h01;
			end
			// saturates at 99:59 rather than wrapping into earlier point times
			if (tick && !(t_hi == `TIMER_HI_MAX && t_lo == `TIMER_LO_MAX)) begin
				if (t_lo == `TIMER_LO_MAX) begin
					t_lo <= 6'h00;
					t_hi <= t_hi + 7'h01;
				end else begin
					t_lo <= t_lo + 6'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// drive outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || state != sched_pkg::ST_RUN) begin
			freq_o <= 16'h0000;
			dir_o <= `DIR_STOP;
		end else if (pt_due && !pt_unset) begin
			freq_o <= cur_set[15:0];
			dir_o <= (cur_set[31:16] == 16'(`DIR_FWD)) ? `DIR_FWD :
				(cur_set[31:16] == 16'(`DIR_REV)) ? `DIR_REV : `DIR_STOP;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || term_i.timer_clear_input || start_go) begin
			term_o.completion_output <= 1'b0;
		end else if (state == sched_pkg::ST_NEXT && rem == 3'h0) begin
			term_o.completion_output <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || term_i.timer_clear_input || state != sched_pkg::ST_RUN || out_assign != `ASSIGN_GROUPS) begin
			term_o.group_one_active_output <= 1'b0;
			term_o.group_two_active_output <= 1'b0;
			term_o.group_three_active_output <= 1'b0;
		end else begin
			term_o.group_one_active_output <= (grp == 2'h0);
			term_o.group_two_active_output <= (grp == 2'h1);
			term_o.group_three_active_output <= (grp == 2'h2);
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign ev = {term_i.power_fail && state != sched_pkg::ST_HALT,
		state == sched_pkg::ST_NEXT && rem == 3'h0, state == sched_pkg::ST_NEXT};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= 3'h0;
		end else if (wr_stb && sel_i[0] && adr_i == `REG_STATUS) begin
			status <= (status & ~dat_i[2:0]) | ev;
		end else begin
			status <= status | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & mask);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_clear_req;
		term_i.timer_clear_input && !term_i.power_fail;
	endsequence

	sequence s_start_taken;
		state == sched_pkg::ST_IDLE ##1 state == sched_pkg::ST_RUN;
	endsequence

	a_timer_zeroed: assert property (@(posedge clk_i) disable iff (rst_i)
		s_clear_req |=> t_val == 14'h0000)
		else $error("timer not zero after clear");

	a_start_needs: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start_taken |-> $past(run_ok) && $past(op_mode) == `MODE_SCHED)
		else $error("run began without valid start");

	a_start_timer: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start_taken |-> t_val == 14'h0000 && pidx == 4'h0)
		else $error("run began without timer cleared");

	a_done_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
		s_clear_req ##1 1'b1 |-> !term_o.completion_output)
		else $error("completion stayed after clear");

	a_done_last: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(term_o.completion_output) |-> $past(state, 1) == sched_pkg::ST_NEXT && $past(rem) == 3'h0)
		else $error("completion before last group");

	a_group_active: assert property (@(posedge clk_i) disable iff (rst_i)
		term_o.group_one_active_output || term_o.group_two_active_output || term_o.group_three_active_output
		|-> $past(out_assign) == `ASSIGN_GROUPS && $past(state) == sched_pkg::ST_RUN)
		else $error("group output without assign setting");

	a_halt_stays: assert property (@(posedge clk_i) disable iff (rst_i)
		term_i.power_fail ##1 term_i.run_start_input [*2] |-> state == sched_pkg::ST_HALT)
		else $error("run resumed after power loss");

	a_dir_legal: assert property (@(posedge clk_i) disable iff (rst_i)
		(freq_o != 16'h0000 || dir_o != `DIR_STOP) |-> dir_o != 2'h3 && $past(state) == sched_pkg::ST_RUN)
		else $error("illegal direction or stray frequency");

	a_unset_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		state == sched_pkg::ST_RUN && pt_unset && !term_i.power_fail && !term_i.timer_clear_input
		&& op_mode == `MODE_SCHED |=> $stable(freq_o) && $stable(dir_o))
		else $error("unset point took effect");

	a_group_ascend: assert property (@(posedge clk_i) disable iff (rst_i)
		state == sched_pkg::ST_NEXT && rem != 3'h0 && !term_i.power_fail && !term_i.timer_clear_input
		&& op_mode == `MODE_SCHED |=> grp > $past(grp) && t_val == 14'h0000)
		else $error("groups not run in ascending order");
endmodule

// ===== test/terminal_switch_model.sv
// model of the external switches and controller on the terminal inputs
module terminal_switch_model (
	input wire logic clk_i,
	input wire logic [2:0] group_i,
	input wire logic start_i,
	input wire logic clear_i,
	input wire logic power_fail_i,
	input wire logic loop_i,
	input wire logic completion_i,
	output sched_pkg::term_in_t term_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial term_o = '0;
	always @(posedge clk_i) begin
		term_o.group_select <= group_i;
		// start waits one edge so the selection is already closed
		term_o.run_start_input <= start_i && (term_o.group_select == group_i);
		// loop mode: completion wired straight back into the timer clear
		term_o.timer_clear_input <= loop_i ? completion_i : clear_i;
		term_o.power_fail <= power_fail_i;
	end
endmodule

// ===== test/time_scheduled_run_sequencer_tb.sv
// self-checking bench for the time-scheduled run sequencer
`include "sched_params.svh"
module time_scheduled_run_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h00000000, dat_r, q;
	logic ack, irq;
	logic [15:0] freq;
	logic [1:0] dir;
	logic [2:0] grp = 3'h0;
	logic start = 1'b0, clear = 1'b0, pfail = 1'b0, loop_en = 1'b0;
	sched_pkg::term_in_t term_in;
	sched_pkg::term_out_t term_out;
	logic [31:0] rnd = 32'h83F228F8;
	logic [15:0] f1, f2, f3, f4;
	logic saw_unset = 1'b0;
	int errors = 0;
	int samples_checked = 0;
	always #25 clk_i = ~clk_i;
	// short second so the run stays brief
	time_scheduled_run_sequencer #(.CYC_PER_SEC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .term_i(term_in),
		.term_o(term_out), .freq_o(freq), .dir_o(dir), .irq_o(irq));
	terminal_switch_model far_side (.clk_i(clk_i), .group_i(grp), .start_i(start), .clear_i(clear),
		.power_fail_i(pfail), .loop_i(loop_en), .completion_i(term_out.completion_output), .term_o(term_in));
	// sticky: an unset point's frequency must never reach the output
	always @(posedge clk_i) begin
		if (freq == f3 && f3 != f1 && f3 != f2 && f3 != f4) begin
			saw_unset <= 1'b1;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] next_freq();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return 16'(rnd % 32'd3999) + 16'h0001;
	endfunction
	function automatic logic [31:0] pt_word(input logic [15:0] f, input logic [1:0] d);
		return {14'h0000, d, f};
	endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat_w <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		q = dat_r;
		// one wait state: ack seen on the second edge after the request
		chk("ack wait", 32'(n), 32'h2);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic prog(input int n, input logic [15:0] f, input logic [1:0] d, input logic [15:0] t);
		wb(1'b1, 12'(`REG_PT_SET + 4 * n), pt_word(f, d));
		wb(1'b1, 12'(`REG_PT_TIME + 4 * n), {16'h0000, t});
	endtask
	// which: 0..3 terminal outputs, 4 applied frequency
	task automatic wait_out(input int which, input logic [15:0] v, input string name);
		int n;
		logic [15:0] seen;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			seen = (which == 4) ? freq : 16'(term_out[which]);
		end while (seen !== v && n < 400);
		chk(name, 32'(seen), 32'(v));
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `REG_CTRL, 32'h0);
		chk("ctrl reset", q, `CTRL_RESET);
		wb(1'b0, 12'h0F0, 32'h0);
		chk("unmapped", q, 32'h0);
		f1 = next_freq();
		f2 = next_freq();
		f3 = next_freq();
		f4 = next_freq();
		prog(0, f1, `DIR_FWD, 16'h0000);
		prog(1, f2, `DIR_REV, 16'h0002);
		prog(2, f3, `DIR_FWD, `PT_UNSET);
		prog(10, f4, `DIR_STOP, 16'h0001);
		// wrong mode: keypad or link operation must not run
		wb(1'b1, `REG_CTRL, 32'h00000031);
		grp <= 3'h1;
		start <= 1'b1;
		repeat (20) @(posedge clk_i);
		chk("no run mode", 32'(term_out), 32'h0);
		chk("no run freq", 32'(freq), 32'h0);
		// clear closed before the mode allows a run, so start must stay refused
		clear <= 1'b1;
		wb(1'b1, `REG_CTRL, 32'h00000035);
		wb(1'b1, `REG_MASK, 32'h00000007);
		repeat (20) @(posedge clk_i);
		wb(1'b0, `REG_STATE, 32'h0);
		chk("held by clear", q & 32'h3F, 32'h1);
		clear <= 1'b0;
		wait_out(0, 16'h1, "group one active");
		wait_out(4, f1, "point 0 freq");
		chk("point 0 dir", 32'(dir), 32'(`DIR_FWD));
		wait_out(4, f2, "point 1 freq");
		chk("point 1 dir", 32'(dir), 32'(`DIR_REV));
		wait_out(3, 16'h1, "completion");
		chk("unset skipped", 32'(saw_unset), 32'h0);
		// irq follows status by one register stage
		@(posedge clk_i);
		chk("irq raised", 32'(irq), 32'h1);
		wb(1'b0, `REG_STATUS, 32'h0);
		chk("status", q & 32'h7, 32'h3);
		wb(1'b1, `REG_STATUS, 32'h3);
		wb(1'b0, `REG_STATUS, 32'h0);
		chk("status cleared", q & 32'h7, 32'h0);
		chk("irq cleared", 32'(irq), 32'h0);
		start <= 1'b0;
		clear <= 1'b1;
		wait_out(3, 16'h0, "completion dropped");
		clear <= 1'b0;
		// two groups back to back, ascending
		grp <= 3'h3;
		start <= 1'b1;
		wait_out(0, 16'h1, "g1 of two");
		wait_out(1, 16'h1, "g2 of two");
		chk("no early completion", 32'(term_out.completion_output), 32'h0);
		wait_out(4, f4, "g2 freq");
		chk("g2 stop dir", 32'(dir), 32'(`DIR_STOP));
		wait_out(3, 16'h1, "two done");
		// completion fed back: the same groups run again
		loop_en <= 1'b1;
		wait_out(0, 16'h1, "loop rerun");
		loop_en <= 1'b0;
		start <= 1'b0;
		clear <= 1'b1;
		repeat (4) @(posedge clk_i);
		clear <= 1'b0;
		// power dropout mid-run must leave it stopped
		grp <= 3'h1;
		start <= 1'b1;
		wait_out(0, 16'h1, "before dropout");
		pfail <= 1'b1;
		repeat (3) @(posedge clk_i);
		pfail <= 1'b0;
		repeat (30) @(posedge clk_i);
		chk("stays stopped", 32'(term_out), 32'h0);
		wb(1'b0, `REG_STATUS, 32'h0);
		chk("power status", q & 32'h4, 32'h4);
		start <= 1'b0;
		repeat (3) @(posedge clk_i);
		start <= 1'b1;
		wait_out(0, 16'h1, "restart");
		clear <= 1'b1;
		wait_out(0, 16'h0, "clear drops group");
		wb(1'b0, `REG_TIMER, 32'h0);
		chk("timer zero", q, 32'h0);
		// hours/minutes unit with group outputs unassigned
		wb(1'b1, `REG_CTRL, 32'h00000105);
		clear <= 1'b0;
		repeat (150) @(posedge clk_i);
		chk("assign off", 32'(term_out) & 32'h7, 32'h0);
		chk("hour unit freq", 32'(freq), 32'(f1));
		wb(1'b0, `REG_TIMER, 32'h0);
		chk("hour unit timer", q, 32'h0);
		// reset in mid-run
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `REG_CTRL, 32'h0);
		chk("ctrl after reset", q, `CTRL_RESET);
		chk("outputs after reset", 32'(term_out), 32'h0);
		chk("freq after reset", 32'(freq), 32'h0);
		chk("irq after reset", 32'(irq), 32'h0);
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		wrap_up();
	end
endmodule
